// ==== common/rwm_pkg.sv ====
package rwm_pkg;

   // Reset release count in oscillator clocks.
   localparam int unsigned RELEASE_CLOCKS = 2048;
   localparam int RELEASE_W = 12;
   localparam logic [11:0] RELEASE_LAST = 12'h7ff;

   // Machine cycle and timer divider lengths.
   localparam logic [3:0] MCYC_LAST = 4'hc;
   localparam logic [3:0] TDIV_LAST = 4'hb;

   // Reset vector address held in the two top program bytes.
   localparam logic [11:0] RESET_VECTOR_LO = 12'hffe;
   localparam logic [11:0] RESET_VECTOR_HI = 12'hfff;

   // Byte cycles taken by each instruction class.
   localparam logic [2:0] CYC_BRANCH_BIT = 3'h5;
   localparam logic [2:0] CYC_LONG = 3'h4;
   localparam logic [2:0] CYC_SHORT = 3'h2;

   // Instruction classes as reported by the decoder.
   typedef enum logic [1:0] {
      ICLS_BRANCH_BIT = 2'h0,
      ICLS_LONG = 2'h1,
      ICLS_SHORT = 2'h2
   } rwm_icls_t;

   // Core operating modes.
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h1,
      MODE_INT = 3'h2,
      MODE_NMI = 3'h4
   } rwm_mode_t;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_COUNT = 4'h2,
      ST_RUN = 4'h4,
      ST_WAIT = 4'h8
   } rwm_state_t;

   // Instruction boundary report from the core.
   typedef struct packed {
      logic done;
      logic wait_req;
      logic stop_req;
      logic return_from_interrupt;
      rwm_icls_t icls;
   } rwm_instr_t;

   // Interrupt request summary from the interrupt logic.
   typedef struct packed {
      logic global_interrupt_enable;
      logic norm_pend;
      logic nmi_pend;
      logic any_src_enabled;
   } rwm_irq_t;

endpackage

// ==== design/rwm_sequencer.sv ====
`timescale 1ns/10ps

// Functional notes
// [RULE1] Reset clears stack, loads reset vector.
// [RULE2] Restart begins in non-maskable mode.
// [RULE3] Return at restart end enters normal mode.
// [RULE4] Oscillator disabled while reset pin low.
// [RULE5] Leave reset after 2048 conditioned clocks.
// [RULE6] Stop instruction behaves as wait.
// [RULE7] Wait halts core, oscillator keeps running.
// [RULE8] Reset exits wait through full procedure.
// [RULE9] Interrupt wake has no start-up delay.
// [RULE10] Wake needs global enable; else NMI ignored.
// [RULE11] Wait from main: service, then continue.
// [RULE12] Wait in NMI: continue, stay NMI mode.
// [RULE13] Wait in interrupt, normal wake: continue.
// [RULE14] Wait in interrupt, NMI wake: NMI first.
// [RULE15] Pending enabled interrupt skips wait.
// [RULE16] No sources enabled: only reset exits.
// [RULE17] Machine cycle is thirteen oscillator pulses.
// [RULE18] Timer and watchdog clock divide by twelve.
// [RULE19] Instructions take five, four or two cycles.
// [RULE20] Short reset pulses are latched internally.
// [RULE21] Watchdog reset pulls pin low, then releases.
// [RULE22] Cleared global enable still passes NMI.
// [RULE23] Dividers held cleared during reset.
module rwm_sequencer (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic reset_pin_i,
   input wire logic wdog_end_i,
   input wire rwm_pkg::rwm_instr_t instr_i,
   input wire rwm_pkg::rwm_irq_t irq_i,
   output logic osc_enable_o,
   output logic core_reset_o,
   output logic reset_pin_oe_n_o,
   output logic reset_pin_o,
   output logic wdog_clear_o,
   output logic stack_clear_o,
   output logic [11:0] vector_addr_o,
   output logic core_run_o,
   output logic waiting_o,
   output logic [2:0] core_mode_o,
   output logic take_normal_o,
   output logic take_nmi_o,
   output logic mcycle_en_o,
   output logic timer_clk_en_o,
   output logic [2:0] instr_cycles_o
);

   // Pin synchroniser stages; only the second stage is read by logic.
   logic rpin_meta_ff;
   logic rpin_ff;
   rwm_pkg::rwm_state_t state_ff;
   rwm_pkg::rwm_state_t nxt_state;
   rwm_pkg::rwm_mode_t mode_ff;
   rwm_pkg::rwm_mode_t nxt_mode;
   rwm_pkg::rwm_mode_t wait_mode_ff;
   logic [11:0] rel_cnt_ff;
   logic rst_req_ff;
   logic wd_pull_ff;
   logic [3:0] mcyc_ff;
   logic [3:0] tdiv_ff;
   logic in_reset;
   logic wake;
   logic stay_nmi;
   logic wait_go;

   // Two-flop synchroniser for the external reset pin.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rpin_meta_ff <= 1'b0;
         rpin_ff <= 1'b0;
      end else begin
         rpin_meta_ff <= reset_pin_i;
         rpin_ff <= rpin_meta_ff;
      end
   end

   // A low pin or a watchdog end-of-count is held until the count restarts.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_req_ff <= 1'b1;
      end else if (!rpin_ff || wdog_end_i) begin
         rst_req_ff <= 1'b1; // see [RULE20] see [RULE21]
      end else if (state_ff == rwm_pkg::ST_RESET) begin
         rst_req_ff <= 1'b0;
      end
   end

   // Watchdog pull-down lasts until the watchdog has been cleared.
   // Three cycles of pull-down are enough here because the pin is re-sampled.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wd_pull_ff <= 1'b0;
      end else if (wdog_end_i) begin
         wd_pull_ff <= 1'b1; // see [RULE21]
      end else if (wdog_clear_o) begin
         wd_pull_ff <= 1'b0;
      end
   end

   // Pin driver and watchdog clear follow the pull-down request.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reset_pin_oe_n_o <= 1'b1;
         reset_pin_o <= 1'b0;
         wdog_clear_o <= 1'b0;
      end else begin
         reset_pin_oe_n_o <= !(wdog_end_i || wd_pull_ff); // see [RULE21]
         reset_pin_o <= 1'b0;
         wdog_clear_o <= wd_pull_ff && !wdog_clear_o; // see [RULE21]
      end
   end

   assign in_reset = rst_req_ff || !rpin_ff || wdog_end_i;

   // Wake needs global enable; NMI passes only when awake.
   assign wake = irq_i.global_interrupt_enable && (irq_i.norm_pend || irq_i.nmi_pend);
   assign stay_nmi = (mode_ff == rwm_pkg::MODE_NMI);
   // A wait or stop request enters wait unless an enabled request already waits.
   // Any enabled request skips the wait, whatever mode the core is in.
   assign wait_go = instr_i.done && (instr_i.wait_req || instr_i.stop_req) // see [RULE6]
                    && !(irq_i.nmi_pend
                         || (irq_i.global_interrupt_enable && irq_i.norm_pend)); // see [RULE15]

   // Sequencer state transitions.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rwm_pkg::ST_RESET: begin
            if (rpin_ff && !wdog_end_i) begin
               nxt_state = rwm_pkg::ST_COUNT;
            end
         end
         rwm_pkg::ST_COUNT: begin
            if (in_reset && !rpin_ff) begin
               nxt_state = rwm_pkg::ST_RESET;
            end else if (rel_cnt_ff == rwm_pkg::RELEASE_LAST) begin
               nxt_state = rwm_pkg::ST_RUN; // see [RULE5]
            end
         end
         rwm_pkg::ST_RUN: begin
            if (!rpin_ff || wdog_end_i) begin
               nxt_state = rwm_pkg::ST_RESET;
            end else if (wait_go) begin
               nxt_state = rwm_pkg::ST_WAIT; // see [RULE7]
            end
         end
         rwm_pkg::ST_WAIT: begin
            if (!rpin_ff || wdog_end_i) begin
               nxt_state = rwm_pkg::ST_RESET; // see [RULE8] see [RULE16]
            end else if (wake) begin
               nxt_state = rwm_pkg::ST_RUN; // see [RULE9] see [RULE10]
            end
         end
         default: begin
            nxt_state = rwm_pkg::ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= rwm_pkg::ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Release counter runs only in the counting state.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rel_cnt_ff <= 12'h000;
      end else if (state_ff != rwm_pkg::ST_COUNT) begin
         rel_cnt_ff <= 12'h000;
      end else begin
         rel_cnt_ff <= rel_cnt_ff + 12'h001; // see [RULE5]
      end
   end

   // Core mode tracking and interrupt acceptance decisions.
   always_comb begin
      nxt_mode = mode_ff;
      take_normal_o = 1'b0;
      take_nmi_o = 1'b0;
      if (state_ff == rwm_pkg::ST_RESET || state_ff == rwm_pkg::ST_COUNT) begin
         nxt_mode = rwm_pkg::MODE_NMI; // see [RULE2]
      end else if (state_ff == rwm_pkg::ST_WAIT && wake) begin
         case (wait_mode_ff)
            rwm_pkg::MODE_NORMAL: begin
               take_nmi_o = irq_i.nmi_pend; // see [RULE11]
               take_normal_o = !irq_i.nmi_pend;
            end
            rwm_pkg::MODE_INT: begin
               take_nmi_o = irq_i.nmi_pend; // see [RULE13] see [RULE14]
            end
            default: begin
               take_nmi_o = 1'b0; // see [RULE12]
            end
         endcase
      end else if (state_ff == rwm_pkg::ST_RUN && !wait_go) begin
         if (instr_i.done && instr_i.return_from_interrupt) begin
            // see [RULE3]
            nxt_mode = (mode_ff == rwm_pkg::MODE_NMI) ? rwm_pkg::MODE_NORMAL : rwm_pkg::MODE_NORMAL;
         end else if (instr_i.done && irq_i.nmi_pend && !stay_nmi) begin
            take_nmi_o = 1'b1; // see [RULE22]
         end else if (instr_i.done && irq_i.norm_pend && irq_i.global_interrupt_enable
                      && mode_ff == rwm_pkg::MODE_NORMAL) begin
            take_normal_o = 1'b1; // see [RULE22]
         end
      end
      if (take_nmi_o) begin
         nxt_mode = rwm_pkg::MODE_NMI;
      end else if (take_normal_o) begin
         nxt_mode = rwm_pkg::MODE_INT;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_ff <= rwm_pkg::MODE_NMI;
         wait_mode_ff <= rwm_pkg::MODE_NMI;
      end else begin
         mode_ff <= nxt_mode;
         if (state_ff == rwm_pkg::ST_RUN && wait_go) begin
            wait_mode_ff <= mode_ff;
         end
      end
   end

   // Status outputs towards the core, all registered.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_enable_o <= 1'b0;
         core_reset_o <= 1'b1;
         stack_clear_o <= 1'b1;
         vector_addr_o <= rwm_pkg::RESET_VECTOR_LO;
         core_run_o <= 1'b0;
         waiting_o <= 1'b0;
         core_mode_o <= rwm_pkg::MODE_NMI;
      end else begin
         osc_enable_o <= rpin_ff; // see [RULE4]
         core_reset_o <= (nxt_state == rwm_pkg::ST_RESET) || (nxt_state == rwm_pkg::ST_COUNT);
         stack_clear_o <= (nxt_state == rwm_pkg::ST_RESET) || (nxt_state == rwm_pkg::ST_COUNT); // see [RULE1]
         vector_addr_o <= rwm_pkg::RESET_VECTOR_LO; // see [RULE1]
         core_run_o <= (nxt_state == rwm_pkg::ST_RUN); // see [RULE7]
         waiting_o <= (nxt_state == rwm_pkg::ST_WAIT);
         core_mode_o <= nxt_mode;
      end
   end

   // Machine-cycle and timer dividers, cleared while in reset.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mcyc_ff <= 4'h0;
         tdiv_ff <= 4'h0;
         mcycle_en_o <= 1'b0;
         timer_clk_en_o <= 1'b0;
      end else if (state_ff == rwm_pkg::ST_RESET || state_ff == rwm_pkg::ST_COUNT) begin
         mcyc_ff <= 4'h0; // see [RULE23]
         tdiv_ff <= 4'h0;
         mcycle_en_o <= 1'b0;
         timer_clk_en_o <= 1'b0;
      end else begin
         mcyc_ff <= (mcyc_ff == rwm_pkg::MCYC_LAST) ? 4'h0 : mcyc_ff + 4'h1; // see [RULE17]
         tdiv_ff <= (tdiv_ff == rwm_pkg::TDIV_LAST) ? 4'h0 : tdiv_ff + 4'h1; // see [RULE18]
         // Looking ahead keeps a pulse from escaping into the first reset cycle.
         mcycle_en_o <= (mcyc_ff == rwm_pkg::MCYC_LAST) && (nxt_state == rwm_pkg::ST_RUN);
         timer_clk_en_o <= (tdiv_ff == rwm_pkg::TDIV_LAST);
      end
   end

   // Byte-cycle count for the reported instruction class.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         instr_cycles_o <= rwm_pkg::CYC_SHORT;
      end else begin
         case (instr_i.icls)
            rwm_pkg::ICLS_BRANCH_BIT: instr_cycles_o <= rwm_pkg::CYC_BRANCH_BIT; // see [RULE19]
            rwm_pkg::ICLS_LONG: instr_cycles_o <= rwm_pkg::CYC_LONG;
            default: instr_cycles_o <= rwm_pkg::CYC_SHORT;
         endcase
      end
   end

endmodule

// ==== sim/rwm_core_model.sv ====
`timescale 1ns/10ps

// Core stand-in that reports one instruction boundary for each go request made while it runs.
module rwm_core_model (
   input wire logic clk_sys_i,
   input wire logic run_i,
   input wire logic go_i,
   input wire logic [1:0] op_i,
   input wire rwm_pkg::rwm_icls_t icls_i,
   output rwm_pkg::rwm_instr_t instr_o
);
   // A halted core fetches nothing, so no boundary is reported outside run.
   always_comb begin
      instr_o.done = go_i && run_i && clk_sys_i !== 1'bx;
      instr_o.wait_req = op_i == 2'h1;
      instr_o.stop_req = op_i == 2'h2;
      instr_o.return_from_interrupt = op_i == 2'h3;
      instr_o.icls = icls_i;
   end
endmodule

// ==== sim/rwm_sequencer_assertions.sv ====
`timescale 1ns/10ps

// Pin-level checker; helper counters measure the release and divider spacing.
module rwm_sequencer_assertions (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic reset_pin_i,
   input wire logic wdog_end_i,
   input wire rwm_pkg::rwm_instr_t instr_i,
   input wire rwm_pkg::rwm_irq_t irq_i,
   input wire logic osc_enable_o,
   input wire logic core_reset_o,
   input wire logic reset_pin_oe_n_o,
   input wire logic stack_clear_o,
   input wire logic [11:0] vector_addr_o,
   input wire logic core_run_o,
   input wire logic waiting_o,
   input wire logic [2:0] core_mode_o,
   input wire logic mcycle_en_o,
   input wire logic timer_clk_en_o
);
   logic [11:0] hi_cnt_ff;
   logic [3:0] m_cnt_ff;
   logic [3:0] t_cnt_ff;
   logic m_ok_ff;
   logic t_ok_ff;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // Cycles the pin has been high; saturates so a long run never wraps.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hi_cnt_ff <= 12'h000;
      end else if (!reset_pin_i) begin
         hi_cnt_ff <= 12'h000;
      end else if (hi_cnt_ff != 12'hfff) begin
         hi_cnt_ff <= hi_cnt_ff + 12'h001;
      end
   end
   // Spacing of machine cycle pulses, only judged between two pulses in run.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         m_cnt_ff <= 4'h0;
         m_ok_ff <= 1'b0;
      end else begin
         m_cnt_ff <= mcycle_en_o ? 4'h0 : m_cnt_ff + 4'h1;
         if (!core_run_o) begin
            m_ok_ff <= 1'b0;
         end else if (mcycle_en_o) begin
            m_ok_ff <= 1'b1;
         end
      end
   end
   // Spacing of timer clock pulses outside reset.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         t_cnt_ff <= 4'h0;
         t_ok_ff <= 1'b0;
      end else begin
         t_cnt_ff <= timer_clk_en_o ? 4'h0 : t_cnt_ff + 4'h1;
         if (core_reset_o) begin
            t_ok_ff <= 1'b0;
         end else if (timer_clk_en_o) begin
            t_ok_ff <= 1'b1;
         end
      end
   end
   AST_OSC_PIN: assert property ($stable(reset_pin_i) [*4] |-> osc_enable_o == reset_pin_i)
      else $error("oscillator enable does not follow pin");
   AST_RELEASE: assert property ($fell(core_reset_o) |-> hi_cnt_ff >= 12'h800)
      else $error("reset left before full count");
   AST_RESTART_NMI: assert property ($fell(core_reset_o) |-> core_mode_o == rwm_pkg::MODE_NMI)
      else $error("restart not in non-maskable mode");
   AST_VECTOR: assert property (core_reset_o |-> stack_clear_o
      && vector_addr_o == rwm_pkg::RESET_VECTOR_LO)
      else $error("stack or vector wrong in reset");
   AST_STOP_WAIT: assert property (instr_i.done && instr_i.stop_req && core_run_o
      && !irq_i.nmi_pend && !irq_i.norm_pend && reset_pin_i
      |-> ##[1:2] (waiting_o && !core_run_o && osc_enable_o))
      else $error("stop did not enter wait");
   AST_SKIP_WAIT: assert property (instr_i.done && instr_i.wait_req && core_run_o
      && irq_i.global_interrupt_enable && irq_i.norm_pend |=> !waiting_o [*2])
      else $error("wait entered with enabled request pending");
   AST_HOLD_WAIT: assert property (waiting_o && reset_pin_i && !wdog_end_i
      && (!irq_i.global_interrupt_enable || !(irq_i.nmi_pend || irq_i.norm_pend))
      |=> waiting_o)
      else $error("wait left without a valid wake");
   AST_FAST_WAKE: assert property (waiting_o && reset_pin_i && irq_i.global_interrupt_enable
      && (irq_i.nmi_pend || irq_i.norm_pend) |-> ##[1:2] core_run_o)
      else $error("wake from wait was delayed");
   AST_WDOG_PULL: assert property (wdog_end_i && !core_reset_o |-> ##[1:2] !reset_pin_oe_n_o)
      else $error("watchdog end did not pull pin");
   AST_MCYCLE: assert property (mcycle_en_o && m_ok_ff |-> m_cnt_ff == 4'hc)
      else $error("machine cycle not thirteen clocks");
   AST_TIMER: assert property (timer_clk_en_o && t_ok_ff |-> t_cnt_ff == 4'hb)
      else $error("timer clock not twelve clocks");
   AST_DIV_HOLD: assert property (core_reset_o |-> !mcycle_en_o)
      else $error("machine cycle pulse during reset");
   cover property ($rose(core_run_o));
   cover property ($rose(waiting_o));
   cover property (!reset_pin_oe_n_o);
endmodule

bind rwm_sequencer rwm_sequencer_assertions i_rwm_sequencer_assertions (.clk_sys_i, .resetn_i,
   .reset_pin_i, .wdog_end_i, .instr_i, .irq_i, .osc_enable_o, .core_reset_o, .reset_pin_oe_n_o,
   .stack_clear_o, .vector_addr_o, .core_run_o, .waiting_o, .core_mode_o, .mcycle_en_o,
   .timer_clk_en_o);

// ==== sim/rwm_sequencer_tb.sv ====
`timescale 1ns/10ps

// Self-checking bench for the reset and wait sequencer.
module rwm_sequencer_tb;
   logic clk_sys_i, resetn_i, ext_pin, wdog_end_i, go, osc_enable_o, core_reset_o;
   logic reset_pin_oe_n_o, reset_pin_o, stack_clear_o, core_run_o, waiting_o;
   logic mcycle_en_o, timer_clk_en_o, reset_pin_i;
   logic [1:0] op;
   logic [2:0] core_mode_o, instr_cycles_o;
   logic [11:0] vector_addr_o;
   rwm_pkg::rwm_icls_t icls;
   rwm_pkg::rwm_instr_t instr_i;
   rwm_pkg::rwm_irq_t irq_i;
   int n_fail = 0;
   int n_compared = 0;
   // The pin has a pull-up, so it is low only when someone pulls it down.
   assign reset_pin_i = ext_pin & (reset_pin_oe_n_o | reset_pin_o);
   rwm_sequencer i_rwm_sequencer (.clk_sys_i, .resetn_i, .reset_pin_i, .wdog_end_i, .instr_i,
      .irq_i, .osc_enable_o, .core_reset_o, .reset_pin_oe_n_o, .reset_pin_o, .wdog_clear_o(),
      .stack_clear_o, .vector_addr_o, .core_run_o, .waiting_o, .core_mode_o, .take_normal_o(),
      .take_nmi_o(), .mcycle_en_o, .timer_clk_en_o, .instr_cycles_o);
   rwm_core_model i_rwm_core_model (.clk_sys_i, .run_i(core_run_o), .go_i(go), .op_i(op),
      .icls_i(icls), .instr_o(instr_i));
   // Oscillator clock at 40 MHz.
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask
   // Waits a bounded time for run and checks the span against lo..hi cycles.
   task automatic t_run(input int lo, input int hi);
      int n;
      n = 0;
      while (core_run_o !== 1'b1 && n < 3000) begin
         cyc(1);
         n++;
      end
      chk({11'h0, n >= lo && n <= hi}, 12'h001);
   endtask
   task automatic issue(input logic [1:0] o, input rwm_pkg::rwm_icls_t c);
      go = 1'b1;
      op = o;
      icls = c;
      cyc(1);
      go = 1'b0;
      op = 2'h0;
   endtask
   task automatic t_power_on;
      chk(osc_enable_o, 1'b0);
      chk(stack_clear_o, 1'b1);
      chk(vector_addr_o, 12'hffe);
      ext_pin = 1'b1;
      t_run(2048, 2053);
      chk(osc_enable_o, 1'b1);
      chk(core_mode_o, rwm_pkg::MODE_NMI);
      issue(2'h3, rwm_pkg::ICLS_SHORT);
      cyc(2);
      chk(core_mode_o, rwm_pkg::MODE_NORMAL);
   endtask
   task automatic t_cycles;
      rwm_pkg::rwm_icls_t c[3] = '{rwm_pkg::ICLS_BRANCH_BIT, rwm_pkg::ICLS_LONG,
         rwm_pkg::ICLS_SHORT};
      logic [2:0] e[3] = '{3'h5, 3'h4, 3'h2};
      for (int i = 0; i < 3; i++) begin
         issue(2'h0, c[i]);
         cyc(1);
         chk(instr_cycles_o, e[i]);
      end
   endtask
   task automatic t_wait;
      irq_i = '{global_interrupt_enable: 1'b1, norm_pend: 1'b1, default: 1'b0};
      issue(2'h1, rwm_pkg::ICLS_SHORT);
      cyc(2);
      chk(waiting_o, 1'b0);
      irq_i = '0;
      // The skipped wait let the request in; return to the main routine first.
      issue(2'h3, rwm_pkg::ICLS_SHORT);
      cyc(1);
      chk(core_mode_o, rwm_pkg::MODE_NORMAL);
      issue(2'h2, rwm_pkg::ICLS_SHORT);
      cyc(2);
      chk(waiting_o, 1'b1);
      chk(osc_enable_o, 1'b1);
      irq_i.nmi_pend = 1'b1;
      cyc(5);
      chk(waiting_o, 1'b1);
      irq_i = '{global_interrupt_enable: 1'b1, norm_pend: 1'b1, default: 1'b0};
      t_run(0, 2);
      cyc(1);
      chk(core_mode_o, rwm_pkg::MODE_INT);
      irq_i.norm_pend = 1'b0;
   endtask
   // Watchdog end-of-count out of wait mode, then a one-cycle pin pulse.
   task automatic t_resets;
      issue(2'h2, rwm_pkg::ICLS_SHORT);
      cyc(2);
      wdog_end_i = 1'b1;
      cyc(1);
      wdog_end_i = 1'b0;
      cyc(1);
      chk(reset_pin_oe_n_o, 1'b0);
      chk(core_reset_o, 1'b1);
      t_run(2048, 2070);
      ext_pin = 1'b0;
      cyc(1);
      ext_pin = 1'b1;
      cyc(4);
      chk(core_reset_o, 1'b1);
      t_run(2040, 2060);
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence; inputs change on falling edges only.
   initial begin
      resetn_i = 1'b0;
      ext_pin = 1'b0;
      wdog_end_i = 1'b0;
      go = 1'b0;
      op = 2'h0;
      icls = rwm_pkg::ICLS_SHORT;
      irq_i = '0;
      cyc(8);
      resetn_i = 1'b1;
      cyc(1);
      t_power_on();
      t_cycles();
      t_wait();
      t_resets();
      end_of_test();
   end
   // The run needs about 6200 cycles; twice that means a hang.
   initial begin
      repeat (13000) @(posedge clk_sys_i);
      n_fail++;
      end_of_test();
   end
endmodule
